// file: core/uart_rx_pkg.sv
// constants, types and register map of the two-channel receive path
// assumes a single 100 MHz clock and a plain strobe register port
// Overview of operation
// (RULE_01) two identical channels 0 and 1, each with its own receive pin
// (RULE_02) data bits sampled at oversamples 8, 9, 10; two of three win
// (RULE_03) each bit shifts into the shift register once its vote is known
// (RULE_04) double speed uses its own eight-sample scheme instead
// (RULE_05) stop bit accepted on majority one, otherwise framing error set
// (RULE_06) software checks the framing error flag before reading data
// (RULE_07) a finished character moves to holding register and sets complete flag unless previous is unread
// (RULE_08) data port reads holding register, writes transmit data register
// (RULE_09) nine-bit mode copies ninth received bit at the transfer
// (RULE_10) character finishing while previous unread sets overrun, is dropped
// (RULE_11) overrun flag visible value updates when holding register is read
// (RULE_12) software checks overrun after each data read
// (RULE_13) receiver disabled while enable is zero; pin stays general purpose
// (RULE_14) enabled receiver owns pin and forces it to input
// (RULE_15) pull-up latch bit still drives the pull-up while forced input
// (RULE_16) nine-bit select gives nine data bits plus start and stop
// (RULE_17) nine-bit transmit uses the transmit ninth bit, set before the write
// (RULE_18) normal speed oversamples sixteen times, samples numbered 1 to 16
// (RULE_19) start bit accepted only if samples 8, 9, 10 are mostly low
package uart_rx_pkg;
  localparam int NCH = 2;
  localparam int AW = 8;
  localparam int DW = 8;
  localparam int BDW = 12;

  // per-channel registers: channel in addr[4], register in addr[3:0]
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_CSA = 4'h4;
  localparam logic [3:0] OFS_CSB = 4'h8;
  localparam logic [3:0] OFS_BAUD = 4'hc;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_EN = 8'h24;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h28;
  localparam logic [7:0] OFS_PORT = 8'h2c;
  localparam logic [7:0] OFS_PIN = 8'h30;

  // status a fields
  localparam int CSA_RXC = 7;
  localparam int CSA_FE = 4;
  localparam int CSA_DSPD = 1;
  // status b fields
  localparam int CSB_RECEIVER_ENABLE_BIT = 4;
  localparam int CSB_OVR = 3;
  localparam int CSB_CHR9 = 2;
  localparam int CSB_RXB8 = 1;
  localparam int CSB_TXB8 = 0;
  // port register: direction [1:0], pull-up latch [3:2], out value [5:4]
  localparam int PORT_DIR = 0;
  localparam int PORT_PUL = 2;
  localparam int PORT_OUT = 4;
  // interrupt event bits per channel, three per channel
  localparam int EV_RXC = 0;
  localparam int EV_FE = 1;
  localparam int EV_OVR = 2;
  localparam int EV_W = 3;

  localparam logic [BDW-1:0] BAUD_RST = 12'h01f;
  localparam logic [7:0] PORT_RST = 8'h0c;

  // oversampling positions
  localparam logic [4:0] SMP_LAST_NORM = 5'h10;
  localparam logic [4:0] SMP_LAST_DBL = 5'h08;
  localparam logic [4:0] POS_A_NORM = 5'h08;
  localparam logic [4:0] POS_B_NORM = 5'h09;
  localparam logic [4:0] POS_C_NORM = 5'h0a;
  localparam logic [4:0] POS_A_DBL = 5'h04;
  localparam logic [4:0] POS_B_DBL = 5'h05;
  localparam logic [4:0] POS_C_DBL = 5'h06;
  localparam logic [3:0] BITS_8 = 4'h7;
  localparam logic [3:0] BITS_9 = 4'h8;

  typedef struct packed {
    logic receiver_enable_bit;
    logic chr9;
    logic txb8;
    logic dspd;
  } rx_ctrl_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA = 4'b0100,
    ST_STOP = 4'b1000
  } rx_state_t;
endpackage : uart_rx_pkg

// file: core/uart_receive_path.sv
// two receive channels with holding registers, flags, pin muxing and irq
// assumes rx pins are asynchronous and the register port is on clk
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module uart_receive_path
  import uart_rx_pkg::*;
#(
  parameter logic [BDW-1:0] BAUD_DEFAULT = BAUD_RST
) (
  input wire logic clk, // 100 MHz system clock
  input wire logic rstn, // async reset, active low
  input wire logic [AW-1:0] addr, // register address
  input wire logic [DW-1:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [DW-1:0] rdata, // read data, cycle after rd
  input wire logic [NCH-1:0] rx_pin_in, // receive pin pad levels
  output logic [NCH-1:0] rx_pin_out, // general purpose drive value
  output logic [NCH-1:0] rx_pin_oe, // high while pin is driven
  output logic [NCH-1:0] rx_pin_pullup, // pull-up enable
  output logic irq // level interrupt
);

  logic [DW-1:0] rdata_r;
  logic irq_r;
  logic [NCH-1:0] pin_out_r;
  logic [NCH-1:0] pin_oe_r;
  logic [NCH-1:0] pullup_r;
  logic [NCH*EV_W-1:0] irq_stat_r;
  logic [NCH*EV_W-1:0] irq_en_r;
  logic [7:0] port_r;
  logic [NCH-1:0] rx_s1_r;
  logic [NCH-1:0] rx_s2_r;

  logic [NCH*EV_W-1:0] ev;
  logic [NCH-1:0] receiver_enable_bit_v;
  logic [DW-1:0] ch_rd [NCH];

  wire ch_space = (addr[7:5] == 3'b000);
  wire wr_stat_clr = wr && (addr == OFS_IRQ_CLR);
  wire wr_irq_en = wr && (addr == OFS_IRQ_EN);
  wire wr_port = wr && (addr == OFS_PORT);
  wire [NCH-1:0] dir_bits = port_r[PORT_DIR +: NCH];
  wire [NCH-1:0] pul_bits = port_r[PORT_PUL +: NCH];
  wire [NCH-1:0] out_bits = port_r[PORT_OUT +: NCH];

  // pin owner: receiver forces input, latch bit keeps pull-up control
  wire [NCH-1:0] oe_nxt = dir_bits & ~receiver_enable_bit_v; // [RULE_13] [RULE_14]
  wire [NCH-1:0] pullup_nxt = pul_bits & ~oe_nxt; // [RULE_15]
  wire irq_nxt = |(irq_stat_r & irq_en_r);

  wire [DW-1:0] glb_rd =
    (addr == OFS_IRQ_STAT) ? DW'(irq_stat_r) :
    (addr == OFS_IRQ_EN) ? DW'(irq_en_r) :
    (addr == OFS_PORT) ? port_r :
    (addr == OFS_PIN) ? DW'(rx_s2_r) :
    '0;
  wire [DW-1:0] rd_nxt = ch_space ? ch_rd[addr[4]] : glb_rd;

  assign rdata = rdata_r;
  assign irq = irq_r;
  assign rx_pin_out = pin_out_r;
  assign rx_pin_oe = pin_oe_r;
  assign rx_pin_pullup = pullup_r;

  // pad synchroniser
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_s1_r <= '1;
      rx_s2_r <= '1;
    end else begin
      rx_s1_r <= rx_pin_in;
      rx_s2_r <= rx_s1_r;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= '0;
    end else if (rd) begin
      rdata_r <= rd_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port_r <= PORT_RST;
      irq_en_r <= '0;
    end else begin
      if (wr_port) port_r <= wdata;
      if (wr_irq_en) irq_en_r <= wdata[NCH*EV_W-1:0];
    end
  end

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r &
        ~(wr_stat_clr ? wdata[NCH*EV_W-1:0] : '0)) | ev;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_r <= 1'b0;
      pin_out_r <= '0;
      pin_oe_r <= '0;
      pullup_r <= '0;
    end else begin
      irq_r <= irq_nxt;
      pin_out_r <= out_bits;
      pin_oe_r <= oe_nxt;
      pullup_r <= pullup_nxt;
    end
  end

  // one receiver per channel
  for (genvar g = 0; g < NCH; g++) begin : g_ch // [RULE_01]
    rx_ctrl_t ctrl_r;
    rx_state_t state_r;
    logic [BDW-1:0] baud_r;
    logic [BDW-1:0] div_r;
    logic [4:0] smp_r;
    logic [3:0] bitn_r;
    logic [8:0] sh_r;
    logic samp_a_r;
    logic samp_b_r;
    logic prev_r;
    logic done_r;
    logic stop_ok_r;
    logic [DW-1:0] hold_r;
    logic [DW-1:0] txd_r;
    logic rxb8_r;
    logic rxc_r;
    logic fe_r;
    logic ovr_pend_r;
    logic ovr_vis_r;

    wire line = rx_s2_r[g];
    wire sel = ch_space && (addr[4] == 1'(g));
    wire rd_data = rd && sel && (addr[3:0] == OFS_DATA);
    wire wr_data = wr && sel && (addr[3:0] == OFS_DATA);
    wire wr_csa = wr && sel && (addr[3:0] == OFS_CSA);
    wire wr_csb = wr && sel && (addr[3:0] == OFS_CSB);
    wire wr_baud = wr && sel && (addr[3:0] == OFS_BAUD);

    // oversample enable pulse from the baud divider
    wire tick = (div_r == '0);

    // positions depend on speed mode
    wire [4:0] last = ctrl_r.dspd ? SMP_LAST_DBL
                                  : SMP_LAST_NORM; // [RULE_18] [RULE_04]
    wire [4:0] pos_a = ctrl_r.dspd ? POS_A_DBL : POS_A_NORM; // [RULE_02]
    wire [4:0] pos_b = ctrl_r.dspd ? POS_B_DBL : POS_B_NORM;
    wire [4:0] pos_c = ctrl_r.dspd ? POS_C_DBL : POS_C_NORM; // [RULE_04]
    wire maj = (samp_a_r & samp_b_r) | (samp_a_r & line) |
               (samp_b_r & line); // [RULE_02]
    wire decide = tick && (smp_r == pos_c);
    wire [3:0] bits_last = ctrl_r.chr9 ? BITS_9 : BITS_8; // [RULE_16]

    // transfer on completion unless the last character is still unread
    wire take = done_r && (!rxc_r || rd_data);
    wire ovr_ev = done_r && rxc_r && !rd_data; // [RULE_10]
    wire [DW-1:0] data_new = ctrl_r.chr9 ? sh_r[7:0] : sh_r[8:1];

    wire [DW-1:0] csa_rd = (DW'(rxc_r) << CSA_RXC) |
      (DW'(fe_r) << CSA_FE) | (DW'(ctrl_r.dspd) << CSA_DSPD);
    wire [DW-1:0] csb_rd = (DW'(ctrl_r.receiver_enable_bit) << CSB_RECEIVER_ENABLE_BIT) |
      (DW'(ovr_vis_r) << CSB_OVR) | (DW'(ctrl_r.chr9) << CSB_CHR9) |
      (DW'(rxb8_r) << CSB_RXB8) | (DW'(ctrl_r.txb8) << CSB_TXB8);

    // reads of the data port see the holding register only
    assign ch_rd[g] = (addr[3:0] == OFS_DATA) ? hold_r : // [RULE_08]
                      (addr[3:0] == OFS_CSA) ? csa_rd :
                      (addr[3:0] == OFS_CSB) ? csb_rd :
                      (addr[3:0] == OFS_BAUD) ? baud_r[DW-1:0] :
                      '0;
    assign receiver_enable_bit_v[g] = ctrl_r.receiver_enable_bit;
    assign ev[g*EV_W + EV_RXC] = take;
    assign ev[g*EV_W + EV_FE] = take && !stop_ok_r;
    assign ev[g*EV_W + EV_OVR] = ovr_ev;

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        ctrl_r <= '0;
      end else begin
        if (wr_csa) begin
          ctrl_r.dspd <= wdata[CSA_DSPD]; // [RULE_04]
        end
        if (wr_csb) begin
          ctrl_r.receiver_enable_bit <= wdata[CSB_RECEIVER_ENABLE_BIT];
          ctrl_r.chr9 <= wdata[CSB_CHR9]; // [RULE_16]
          ctrl_r.txb8 <= wdata[CSB_TXB8]; // [RULE_17]
        end
      end
    end

    // divisor and transmit data register
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        baud_r <= BAUD_DEFAULT;
        txd_r <= '0;
      end else begin
        if (wr_baud) begin
          baud_r <= BDW'(wdata);
        end
        if (wr_data) begin
          txd_r <= wdata; // [RULE_08]
        end
      end
    end

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        div_r <= '0;
      end else if (tick || !ctrl_r.receiver_enable_bit) begin
        div_r <= baud_r;
      end else begin
        div_r <= div_r - 1'b1;
      end
    end

    // state decodes and the strobes of the sequencer
    wire in_idle = (state_r == ST_IDLE);
    wire in_start = (state_r == ST_START);
    wire in_data = (state_r == ST_DATA);
    wire in_stop = (state_r == ST_STOP);
    wire edge_seen = prev_r && !line;
    wire wrap = (smp_r == last); // [RULE_18]
    wire last_bit = (bitn_r == bits_last); // [RULE_16]
    wire start_done = ctrl_r.receiver_enable_bit && decide && in_start;
    wire shift_en = ctrl_r.receiver_enable_bit && decide && in_data;
    wire stop_en = ctrl_r.receiver_enable_bit && decide && in_stop;
    wire [4:0] smp_nxt = (in_idle || wrap) ? 5'h01 : smp_r + 5'h01;
    rx_state_t state_nxt;

    // line sampling on every tick while enabled
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        smp_r <= '0;
        prev_r <= 1'b1;
        samp_a_r <= 1'b1;
        samp_b_r <= 1'b1;
      end else if (!ctrl_r.receiver_enable_bit) begin // [RULE_13]
        smp_r <= '0;
        prev_r <= 1'b1;
      end else if (tick) begin
        smp_r <= smp_nxt; // [RULE_18]
        prev_r <= line;
        if (smp_r == pos_a) samp_a_r <= line; // [RULE_02]
        if (smp_r == pos_b) samp_b_r <= line;
      end
    end

    // receiver sequencer, idle while disabled
    always_comb begin
      state_nxt = state_r;
      case (state_r)
        ST_IDLE: begin
          if (edge_seen) state_nxt = ST_START;
        end
        ST_START: begin
          if (decide) state_nxt = maj ? ST_IDLE : ST_DATA; // [RULE_19]
        end
        ST_DATA: begin
          if (decide && last_bit) state_nxt = ST_STOP;
        end
        ST_STOP: begin
          if (decide) state_nxt = ST_IDLE;
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        state_r <= ST_IDLE;
      end else if (!ctrl_r.receiver_enable_bit) begin // [RULE_13]
        state_r <= ST_IDLE;
      end else if (tick) begin
        state_r <= state_nxt;
      end
    end

    // bits shift in lsb first as soon as each vote is known
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        bitn_r <= '0;
        sh_r <= '0;
      end else if (start_done) begin
        bitn_r <= '0;
      end else if (shift_en) begin
        sh_r <= {maj, sh_r[8:1]}; // [RULE_03]
        bitn_r <= bitn_r + 4'h1;
      end
    end

    // stop vote and end of character strobe
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        stop_ok_r <= 1'b1;
        done_r <= 1'b0;
      end else begin
        done_r <= stop_en; // [RULE_07]
        if (stop_en) stop_ok_r <= maj; // [RULE_05]
      end
    end

    // holding register with its ninth bit and framing flag
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        hold_r <= '0;
        rxb8_r <= 1'b0;
        fe_r <= 1'b0;
      end else if (take) begin
        hold_r <= data_new; // [RULE_07]
        rxb8_r <= ctrl_r.chr9 & sh_r[8]; // [RULE_09]
        fe_r <= !stop_ok_r; // [RULE_05]
      end
    end

    // complete flag: a new character wins over the clearing read
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        rxc_r <= 1'b0;
      end else if (take) begin
        rxc_r <= 1'b1; // [RULE_07]
      end else if (rd_data) begin
        rxc_r <= 1'b0;
      end
    end

    // overrun waits in a pending bit until the data port is read
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        ovr_pend_r <= 1'b0;
        ovr_vis_r <= 1'b0;
      end else if (rd_data) begin
        ovr_vis_r <= ovr_pend_r; // [RULE_11]
        ovr_pend_r <= 1'b0;
      end else if (ovr_ev) begin
        ovr_pend_r <= 1'b1; // [RULE_10]
      end
    end
  end

endmodule : uart_receive_path
`default_nettype wire

// file: bench/uart_rx_checker.sv
// port checks for the two-channel receive path, bound into it
// assumes one clock domain and the register map of the package
`timescale 1ns/1ps
`default_nettype none
module uart_rx_checker
  import uart_rx_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic [AW-1:0] addr, // register address
  input wire logic [DW-1:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [DW-1:0] rdata, // read data
  input wire logic [NCH-1:0] rx_pin_out, // drive value
  input wire logic [NCH-1:0] rx_pin_oe, // output enable
  input wire logic [NCH-1:0] rx_pin_pullup, // pull-up enable
  input wire logic irq // level interrupt
);
  logic [7:0] port_r;
  logic [1:0] en_r;
  logic [7:0] ien_r;
  wire logic [1:0] gpo = port_r[1:0] & ~en_r;
  wire logic [1:0] pul = port_r[3:2] & ~gpo;
  // shadow of the registers that steer the pins and the interrupt
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port_r <= PORT_RST;
      en_r <= 2'b00;
      ien_r <= 8'h00;
    end else if (wr) begin
      if (addr == OFS_PORT) port_r <= wdata;
      if (addr == 8'h08) en_r[0] <= wdata[CSB_RECEIVER_ENABLE_BIT];
      if (addr == 8'h18) en_r[1] <= wdata[CSB_RECEIVER_ENABLE_BIT];
      if (addr == OFS_IRQ_EN) ien_r <= wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_gpio_drive:
    assert property ($past(rstn, 3) && gpo == $past(gpo) |-> rx_pin_oe == gpo)
    else $error("pin enable differs from port setting");
  chk_gpio_value:
    assert property ($past(rstn, 3) && port_r[5:4] == $past(port_r[5:4])
      |-> rx_pin_out == port_r[5:4]) else $error("pin drive value wrong");
  chk_forced_input:
    assert property ($past(rstn, 3) && en_r == $past(en_r)
      |-> (rx_pin_oe & en_r) == 2'b00) else $error("enabled pin driven");
  chk_pullup_kept:
    assert property ($past(rstn, 3) && pul == $past(pul) && pul == $past(pul, 2)
      |-> rx_pin_pullup == pul) else $error("pull-up differs from latch");
  chk_unmapped_zero:
    assert property (rd && addr >= 8'h34 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_holds:
    assert property (!rd |=> $stable(rdata)) else $error("read data moved");
  chk_irq_masked:
    assert property (irq |-> $past(ien_r) != 8'h00)
    else $error("interrupt with all sources masked");
  chk_irq_clear:
    assert property ($fell(irq) |-> $past(wr) || $past(wr, 2))
    else $error("interrupt dropped without a write");
endmodule : uart_rx_checker
bind uart_receive_path uart_rx_checker u_uart_rx_checker (.clk, .rstn, .addr,
  .wdata, .wr, .rd, .rdata, .rx_pin_out, .rx_pin_oe, .rx_pin_pullup, .irq);
`default_nettype wire

// file: bench/serial_tx_model.sv
// remote serial transmitter driving one receive line
// assumes the bench gives the bit length in system clocks
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model (
  input wire logic clk, // system clock
  output logic line // serial line, pulled high while idle
);
  initial line = 1'b1;
  // start, data lsb first, stop; a zero stop makes a broken frame
  task automatic send(input logic [8:0] d, input int nb, input logic stp,
                      input int bclk);
    for (int i = 0; i < nb + 2; i++) begin
      line <= (i == 0) ? 1'b0 : (i > nb) ? stp : d[i-1];
      repeat (bclk) @(posedge clk);
    end
    line <= 1'b1;
    repeat (bclk) @(posedge clk);
  endtask : send
  // low pulse too short to count as a start bit
  task automatic glitch(input int n);
    line <= 1'b0;
    repeat (n) @(posedge clk);
    line <= 1'b1;
    repeat (40) @(posedge clk);
  endtask : glitch
endmodule : serial_tx_model
`default_nettype wire

// file: bench/tb_top.sv
// self-checking bench for the two-channel receive path
// assumes a transmitter model on each receive pin, divisor set to 1
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import uart_rx_pkg::*;
  localparam int BC = 32; // clocks per bit: 16 ticks of 2 clocks
  logic clk, rstn, wr, rd;
  logic [7:0] addr, wdata, q;
  logic [8:0] d;
  wire logic [7:0] rdata;
  wire logic [1:0] pout, poe, ppu, tx;
  wire logic irq;
  wire logic [1:0] pin = (poe & pout) | (~poe & tx);
  int n_mismatch = 0;
  int checks = 0;
  uart_receive_path #(.BAUD_DEFAULT(12'h001)) u_uart_receive_path (.clk,
    .rstn, .addr, .wdata, .wr, .rd, .rdata, .rx_pin_in(pin),
    .rx_pin_out(pout), .rx_pin_oe(poe), .rx_pin_pullup(ppu), .irq);
  serial_tx_model u_serial_tx_model (.clk, .line(tx[0]));
  serial_tx_model u_serial_tx_model_1 (.clk, .line(tx[1]));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [7:0] csa(input logic c, input logic f,
                                     input logic s);
    return {c, 2'b00, f, 2'b00, s, 1'b0};
  endfunction : csa
  function automatic logic [7:0] csb(input logic e, input logic o,
                                     input logic n, input logic b);
    return {3'b000, e, o, n, b, 1'b0};
  endfunction : csb
  task automatic compare(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare
  task automatic put(input logic [7:0] a, input logic [7:0] v);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : put
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    q = rdata;
    compare(q, exp);
  endtask : expect_reg
  task automatic wait_rx(input logic [7:0] a);
    for (int k = 0; k < 200 && q[CSA_RXC] !== 1'b1; k++) begin
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      q = rdata;
    end
  endtask : wait_rx
  task automatic settle_pins(input logic [7:0] exp);
    @(posedge clk);
    #1 compare({poe, ppu, 2'b00, irq, 1'b0}, exp);
    @(posedge clk);
  endtask : settle_pins
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  initial begin
    #400us;
    n_mismatch++;
    conclude();
  end
  initial begin
    {wr, rd, addr, wdata, rstn, q} = '0;
    void'($urandom(32'hfe94));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    expect_reg(OFS_PORT, PORT_RST);
    expect_reg(8'h34, 8'h00);
    put(OFS_PORT, 8'h3f);
    settle_pins(8'hc0);
    put(8'h08, 8'h10);
    put(8'h18, 8'h14);
    settle_pins(8'h30);
    $display("test pins done");
    for (int i = 0; i < 8; i++) begin
      d = (i < 2) ? {1'b0, {8{i[0]}}} : 9'($urandom());
      u_serial_tx_model.send(d, 8, i != 7, BC >> (i == 6));
      q = 8'h00;
      wait_rx(OFS_CSA);
      compare(q, csa(1'b1, i == 7, i == 6));
      put(OFS_DATA, ~d[7:0]);
      expect_reg(OFS_DATA, d[7:0]);
      put(OFS_CSA, (i == 5) ? 8'h02 : 8'h00);
    end
    $display("test normal, double speed and framing done");
    for (int i = 0; i < 2; i++) begin
      d = {i[0], 8'($urandom())};
      u_serial_tx_model_1.send(d, 9, 1'b1, BC);
      expect_reg(8'h18, csb(1'b1, 1'b0, 1'b1, d[8]));
      expect_reg(8'h10, d[7:0]);
    end
    $display("test nine bits done");
    u_serial_tx_model.glitch(6);
    expect_reg(OFS_CSA, csa(1'b0, 1'b1, 1'b0));
    $display("test false start done");
    put(OFS_IRQ_CLR, 8'h3f);
    put(OFS_IRQ_EN, 8'h05);
    u_serial_tx_model.send(9'h05a, 8, 1'b1, BC);
    u_serial_tx_model.send(9'h05b, 8, 1'b1, BC);
    expect_reg(OFS_CSB, csb(1'b1, 1'b0, 1'b0, 1'b0));
    expect_reg(OFS_DATA, 8'h5a);
    expect_reg(OFS_CSB, csb(1'b1, 1'b1, 1'b0, 1'b0));
    expect_reg(OFS_IRQ_STAT, 8'h05);
    settle_pins(8'h32);
    put(OFS_IRQ_EN, 8'h00);
    settle_pins(8'h30);
    put(OFS_IRQ_EN, 8'h05);
    settle_pins(8'h32);
    put(OFS_IRQ_CLR, 8'h05);
    settle_pins(8'h30);
    expect_reg(OFS_IRQ_STAT, 8'h00);
    $display("test overrun and interrupt done");
    put(OFS_CSB, 8'h00);
    settle_pins(8'h60);
    put(OFS_PORT, 8'h3e);
    settle_pins(8'h30);
    u_serial_tx_model.send(9'h0a5, 8, 1'b1, BC);
    expect_reg(OFS_CSA, csa(1'b0, 1'b0, 1'b0));
    $display("test disabled receiver done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
